// file: dcc_pkg.sv
// Notes on behaviour
// - Muted flag sets after mute; read clears it
// - Mute bit mutes all 64 slew locations
// - Mute zeroes data, keeps ramp bits
// - Bit 10 picks output latch timing source
// - Bit 9 low holds accumulators, outputs zero
// - All control bits reset to zero
// - Bit 8 forces multiplier input zero
// - Bit 7 zero-fills memory, self-clears
// - Bit 6 zeroes all 16 input channels
// - Bit 5 safeloads target RAM, self-clears
// - Bit 4 safeloads parameter RAM, self-clears
// - Only pairs written since last safeload
// - Safeload address zero is first location
// - Bits 3:2 divide frame clock by 1,2,4,8
// - Sequencer restarts on selected frame edge
// - Bits 1:0 set 1536/768/384/192 steps
// - Modulo field counts 512 words, max 12
// - Low addresses offset and wrap, rest direct
// - Offset counter advances once per selected frame edge
// - Safeload finishes within one frame period
package dcc_pkg;
  localparam logic [11:0] DCC_ADDR_CORE   = 12'ha52;
  localparam logic [11:0] DCC_ADDR_RAMCFG = 12'ha53;
  localparam int          DCC_B_MUTED     = 13;
  localparam int          DCC_B_MUTE      = 12;
  localparam int          DCC_B_OLATCH    = 10;
  localparam int          DCC_B_CLR_N     = 9;
  localparam int          DCC_B_FMULT     = 8;
  localparam int          DCC_B_INIT      = 7;
  localparam int          DCC_B_INMUTE    = 6;
  localparam int          DCC_B_SL_TGT    = 5;
  localparam int          DCC_B_SL_PAR    = 4;
  localparam int          DCC_SYNC_LSB    = 2;
  localparam int          DCC_LEN_LSB     = 0;
  localparam logic [15:0] DCC_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] DCC_CTRL_WMASK  = 16'h17ff;
  localparam logic [7:0]  DCC_RAM_RESET   = 8'h00;
  localparam logic [7:0]  DCC_RAM_WMASK   = 8'h0f;
  localparam logic [10:0] DCC_PROG_MAX    = 11'h600;
  localparam logic [12:0] DCC_DM_WORDS    = 13'h1800;
  localparam int          DCC_MOD_SHIFT   = 9;
  localparam logic [3:0]  DCC_MOD_MAX     = 4'hc;
  localparam int          DCC_PAIRS       = 5;
  localparam int          DCC_SL_AW       = 11;
  localparam logic [2:0]  DCC_LAST_PAIR   = 3'h4;
  typedef enum logic [1:0] {
    DCC_SL_IDLE = 2'b00,
    DCC_SL_TGT  = 2'b01,
    DCC_SL_PAR  = 2'b10
  } dcc_sl_e;
endpackage

// file: dcc_core_ctrl.sv
`timescale 1ns/1ns
module dcc_core_ctrl (
  input  wire logic                    clk_sys,
  input  wire logic                    reset_n,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [11:0]             reg_addr,
  input  wire logic [15:0]             reg_wdata,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    lrclk_in,
  input  wire logic                    lrclk_out,
  input  wire logic                    slew_settled,
  input  wire logic [dcc_pkg::DCC_PAIRS-1:0] sl_pair_wr,
  input  wire logic [dcc_pkg::DCC_PAIRS*dcc_pkg::DCC_SL_AW-1:0] sl_pair_addr,
  input  wire logic [12:0]             dm_addr_in,
  output logic      [12:0]             dm_addr_out,
  output logic                         dm_fill_we,
  output logic      [12:0]             dm_fill_addr,
  output logic                         slew_mute,
  output logic                         core_clear_n,
  output logic                         mult_zero,
  output logic                         in_mute,
  output logic                         out_latch,
  output logic      [10:0]             prog_pc,
  output logic                         frame_start,
  output logic                         sl_xfer_valid,
  output logic                         sl_xfer_param,
  output logic      [2:0]              sl_xfer_idx,
  output logic      [dcc_pkg::DCC_SL_AW-1:0] sl_xfer_addr
);
  import dcc_pkg::*;

  logic [15:0]          ctrl_reg,   ctrl_next;
  logic [7:0]           ram_reg,    ram_next;
  logic [15:0]          rdata_next;
  logic                 mdone_reg,  mdone_next;
  logic                 fill_reg,   fill_next;
  logic [12:0]          faddr_reg,  faddr_next;
  dcc_sl_e              sl_reg,     sl_next;
  logic [2:0]           idx_reg,    idx_next;
  logic [DCC_PAIRS-1:0] wrt_reg,    wrt_next;
  logic                 xv_next,    xp_next;
  logic [2:0]           xi_next;
  logic [DCC_SL_AW-1:0] xa_next;
  logic [2:0]           div_reg,    div_next;
  logic [10:0]          pc_reg,     pc_next;
  logic                 run_reg,    run_next;
  logic                 ol_next,    fs_next;
  logic [12:0]          off_reg,    off_next;
  logic [12:0]          phys_next;
  logic [2:0]           li_sync,    lo_sync;
  logic                 wr_core,    rd_core, wr_ram;
  logic                 mdone_now,  lr_edge, lo_edge, sync_edge, eop;
  logic [2:0]           div_mask;
  logic [10:0]          len_last;
  logic [3:0]           mod_eff;
  logic [12:0]          bound;
  logic [13:0]          sum;

  // Pins are asynchronous; only the second and third stages feed logic
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      li_sync <= 3'h0;
      lo_sync <= 3'h0;
    end else begin
      li_sync <= {li_sync[1:0], lrclk_in};
      lo_sync <= {lo_sync[1:0], lrclk_out};
    end
  end

  always_comb begin
    wr_core   = reg_wr && (reg_addr == DCC_ADDR_CORE);
    wr_ram    = reg_wr && (reg_addr == DCC_ADDR_RAMCFG);
    rd_core   = reg_rd && (reg_addr == DCC_ADDR_CORE);
    lr_edge   = li_sync[1] && !li_sync[2];
    lo_edge   = lo_sync[1] && !lo_sync[2];
    mdone_now = ctrl_reg[DCC_B_MUTE] && slew_settled;
    ctrl_next = ctrl_reg;
    ram_next  = ram_reg;
    mdone_next = mdone_now;
    fill_next  = fill_reg;
    faddr_next = faddr_reg;
    sl_next    = sl_reg;
    idx_next   = idx_reg;
    wrt_next   = wrt_reg;
    xv_next    = 1'b0;
    xp_next    = 1'b0;
    xi_next    = idx_reg;
    xa_next    = sl_pair_addr[idx_reg*DCC_SL_AW +: DCC_SL_AW];
    div_next   = div_reg;
    pc_next    = pc_reg;
    run_next   = run_reg;
    eop        = 1'b0;

    // Sync reference: every 1st, 2nd, 4th or 8th input frame edge
    case (ctrl_reg[DCC_SYNC_LSB +: 2])
      2'b00:   div_mask = 3'h0;
      2'b01:   div_mask = 3'h1;
      2'b10:   div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
    if (lr_edge) begin
      div_next = div_reg + 3'h1;
    end
    sync_edge = lr_edge && ((div_reg & div_mask) == 3'h0);
    len_last  = (DCC_PROG_MAX >> ctrl_reg[DCC_LEN_LSB +: 2]) - 11'h1;

    // Program counter relocks to the frame edge even mid-program
    if (sync_edge) begin
      pc_next  = 11'h0;
      run_next = 1'b1;
    end else if (run_reg) begin
      // A length cut below the running count ends the program at once
      if (pc_reg >= len_last) begin
        run_next = 1'b0;
        eop      = 1'b1;
      end else begin
        pc_next = pc_reg + 11'h1;
      end
    end
    fs_next = sync_edge;
    ol_next = ctrl_reg[DCC_B_OLATCH] ? lo_edge : eop;

    // Modulo partition; codes above full memory are clamped
    mod_eff = (ram_reg[3:0] > DCC_MOD_MAX) ? DCC_MOD_MAX : ram_reg[3:0];
    bound   = 13'(mod_eff) << DCC_MOD_SHIFT;
    off_next = off_reg;
    if (sync_edge) begin
      if ({1'b0, off_reg} + 14'h1 >= {1'b0, bound}) begin
        off_next = 13'h0;
      end else begin
        off_next = off_reg + 13'h1;
      end
    end
    sum = {1'b0, dm_addr_in} + {1'b0, off_reg};
    if (dm_addr_in < bound) begin
      phys_next = (sum >= {1'b0, bound}) ? 13'(sum - {1'b0, bound}) : sum[12:0];
    end else begin
      phys_next = dm_addr_in;
    end

    // Zero-fill walks the whole data memory once
    if (fill_reg) begin
      if (faddr_reg == DCC_DM_WORDS - 13'h1) begin
        fill_next = 1'b0;
        ctrl_next[DCC_B_INIT] = 1'b0;
      end else begin
        faddr_next = faddr_reg + 13'h1;
      end
    end else if (ctrl_reg[DCC_B_INIT]) begin
      fill_next  = 1'b1;
      faddr_next = 13'h0;
    end

    // Safeload scan: one pair per cycle, so five cycles fit any frame
    case (sl_reg)
      DCC_SL_IDLE: begin
        idx_next = 3'h0;
        if (ctrl_reg[DCC_B_SL_TGT]) begin
          sl_next = DCC_SL_TGT;
        end else if (ctrl_reg[DCC_B_SL_PAR]) begin
          sl_next = DCC_SL_PAR;
        end
      end
      DCC_SL_TGT, DCC_SL_PAR: begin
        xp_next = (sl_reg == DCC_SL_PAR);
        if (wrt_reg[idx_reg]) begin
          xv_next = 1'b1;
          wrt_next[idx_reg] = 1'b0;
        end
        if (idx_reg == DCC_LAST_PAIR) begin
          sl_next = DCC_SL_IDLE;
          if (sl_reg == DCC_SL_TGT) begin
            ctrl_next[DCC_B_SL_TGT] = 1'b0;
          end else begin
            ctrl_next[DCC_B_SL_PAR] = 1'b0;
          end
        end else begin
          idx_next = idx_reg + 3'h1;
        end
      end
      default: sl_next = DCC_SL_IDLE;
    endcase
    // A pair written at or after its own scan slot is kept for the next safeload
    wrt_next = wrt_next | sl_pair_wr;

    // Register access; a software write wins over the self-clears above
    if (rd_core) begin
      ctrl_next[DCC_B_MUTED] = 1'b0;
    end
    if (wr_core) begin
      ctrl_next = (reg_wdata & DCC_CTRL_WMASK) | (ctrl_next & ~DCC_CTRL_WMASK);
    end
    if (wr_ram) begin
      ram_next = reg_wdata[7:0] & DCC_RAM_WMASK;
    end
    // Completion set wins over a read-clear in the same cycle
    if (mdone_now && !mdone_reg) begin
      ctrl_next[DCC_B_MUTED] = 1'b1;
    end

    rdata_next = 16'h0000;
    if (rd_core) begin
      rdata_next = ctrl_reg;
    end else if (reg_rd && (reg_addr == DCC_ADDR_RAMCFG)) begin
      rdata_next = {8'h00, ram_reg};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg      <= DCC_CTRL_RESET;
      ram_reg       <= DCC_RAM_RESET;
      reg_rdata     <= 16'h0000;
      mdone_reg     <= 1'b0;
      fill_reg      <= 1'b0;
      faddr_reg     <= 13'h0;
      sl_reg        <= DCC_SL_IDLE;
      idx_reg       <= 3'h0;
      wrt_reg       <= '0;
      sl_xfer_valid <= 1'b0;
      sl_xfer_param <= 1'b0;
      sl_xfer_idx   <= 3'h0;
      sl_xfer_addr  <= '0;
      div_reg       <= 3'h0;
      pc_reg        <= 11'h0;
      run_reg       <= 1'b0;
      out_latch     <= 1'b0;
      frame_start   <= 1'b0;
      off_reg       <= 13'h0;
      dm_addr_out   <= 13'h0;
    end else begin
      ctrl_reg      <= ctrl_next;
      ram_reg       <= ram_next;
      reg_rdata     <= rdata_next;
      mdone_reg     <= mdone_next;
      fill_reg      <= fill_next;
      faddr_reg     <= faddr_next;
      sl_reg        <= sl_next;
      idx_reg       <= idx_next;
      wrt_reg       <= wrt_next;
      sl_xfer_valid <= xv_next;
      sl_xfer_param <= xp_next;
      sl_xfer_idx   <= xi_next;
      sl_xfer_addr  <= xa_next;
      div_reg       <= div_next;
      pc_reg        <= pc_next;
      run_reg       <= run_next;
      out_latch     <= ol_next;
      frame_start   <= fs_next;
      off_reg       <= off_next;
      dm_addr_out   <= phys_next;
    end
  end

  // Slew engine zeroes data only; stored ramp bits still shape the fade
  assign slew_mute    = ctrl_reg[DCC_B_MUTE];
  assign core_clear_n = ctrl_reg[DCC_B_CLR_N];
  assign mult_zero    = ctrl_reg[DCC_B_FMULT];
  assign in_mute      = ctrl_reg[DCC_B_INMUTE];
  assign dm_fill_we   = fill_reg;
  assign dm_fill_addr = faddr_reg;
  assign prog_pc      = pc_reg;

  a_muted_sets: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (mdone_now && !mdone_reg) |=> ctrl_reg[DCC_B_MUTED])
    else $error("muted flag not set after mute completed");
  a_muted_rdclr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rd_core && !(mdone_now && !mdone_reg)) |=> !ctrl_reg[DCC_B_MUTED])
    else $error("muted flag survived a read");
  a_mute_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (wr_core && reg_wdata[DCC_B_MUTE]) |=> slew_mute)
    else $error("slew mute did not follow write");
  a_latch_source: assert property (@(posedge clk_sys) disable iff (!reset_n)
    out_latch |-> ($past(ctrl_reg[DCC_B_OLATCH]) ? $past(lo_edge) : $past(eop)))
    else $error("output latch from wrong source");
  a_fill_selfclr: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (fill_reg && faddr_reg == DCC_DM_WORDS - 13'h1 && !wr_core)
    |=> !ctrl_reg[DCC_B_INIT] && !fill_reg)
    else $error("zero-fill did not finish at last word");
  a_sl_written: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sl_xfer_valid |-> ((($past(wrt_reg) >> sl_xfer_idx) & DCC_PAIRS'(1)) != '0))
    else $error("unwritten safeload pair transferred");
  a_sl_bounded: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sl_reg == DCC_SL_IDLE && ctrl_reg[DCC_B_SL_TGT] && !reg_wr)
    ##1 !reg_wr [*6] |-> !ctrl_reg[DCC_B_SL_TGT])
    else $error("target safeload did not complete");
  a_sl_param_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (sl_reg == DCC_SL_PAR && idx_reg == DCC_LAST_PAIR && !wr_core) |=> !ctrl_reg[DCC_B_SL_PAR])
    else $error("parameter safeload bit not cleared");
  a_pc_relock: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sync_edge |=> (pc_reg == 11'h0) && run_reg)
    else $error("sequencer did not relock to frame edge");
  a_pc_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (run_reg && !$changed(ctrl_reg[DCC_LEN_LSB +: 2]))
    |-> pc_reg <= ((DCC_PROG_MAX >> ctrl_reg[DCC_LEN_LSB +: 2]) - 11'h1))
    else $error("program counter past program length");
  a_mod_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dm_addr_in < bound && $stable(bound) && off_reg < bound) |=> dm_addr_out < $past(bound))
    else $error("modulo address escaped partition");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rdata[15:14] == 2'b00 && !reg_rdata[11])
    else $error("reserved bits read nonzero");
endmodule

// file: dcc_host_model.sv
`timescale 1ns/1ns
module dcc_host_model (
  input  wire logic        clk_sys,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [11:0] reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
  end
  // Strobes launched and dropped at the falling edge, one cycle wide
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
  // Shorter programs so the core fits the faster frame
  function automatic logic [1:0] len_for(input int khz);
    return (khz >= 192) ? 2'b10 : (khz >= 96) ? 2'b01 : 2'b00;
  endfunction
  // Slew volume muted ahead of the bit 9 core clear, so no click
  task automatic stop(input logic [15:0] base);
    wr(12'ha52, base | 16'h1000);
    wr(12'ha52, (base | 16'h1000) & 16'hfdff);
  endtask
  // Only once the whole download is in
  task automatic fill(input logic [15:0] base);
    wr(12'ha52, base | 16'h0080);
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import dcc_pkg::*;
  typedef struct packed {
    logic [15:0] wd;
    logic [15:0] rb;
    logic [3:0]  outs;
  } dcc_row_s;
  logic        clk_sys, reset_n, reg_wr, reg_rd, lrclk_in, lrclk_out, slew_settled;
  logic        dm_fill_we, slew_mute, core_clear_n, mult_zero, in_mute, out_latch;
  logic        frame_start, sl_xfer_valid, sl_xfer_param;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  logic [4:0]  sl_pair_wr;
  logic [54:0] sl_pair_addr;
  logic [12:0] dm_addr_in, dm_addr_out, dm_fill_addr, f_first, f_last;
  logic [10:0] prog_pc, sl_xfer_addr;
  logic [2:0]  sl_xfer_idx;
  logic [14:0] seen[$];
  int          n_errors, check_count, n, t;
  dcc_row_s    rows[7];

  dcc_core_ctrl u_dcc_core_ctrl (.clk_sys, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .lrclk_in, .lrclk_out, .slew_settled, .sl_pair_wr, .sl_pair_addr,
    .dm_addr_in, .dm_addr_out, .dm_fill_we, .dm_fill_addr, .slew_mute, .core_clear_n,
    .mult_zero, .in_mute, .out_latch, .prog_pc, .frame_start, .sl_xfer_valid,
    .sl_xfer_param, .sl_xfer_idx, .sl_xfer_addr);
  dcc_host_model u_dcc_host_model (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic frame();
    lrclk_in = 1'b1;
    t = 0;
    while (frame_start !== 1'b1 && t < 10) begin
      @(negedge clk_sys);
      t++;
    end
    lrclk_in = 1'b0;
    if (t == 10) begin
      chk("frame_start", 16'h0001, 16'h0000);
      wrap_up();
    end
  endtask
  task automatic sl_run(input logic [4:0] pw, input logic [15:0] trig);
    @(negedge clk_sys);
    sl_pair_wr = pw;
    @(negedge clk_sys);
    sl_pair_wr = 5'h00;
    u_dcc_host_model.wr(DCC_ADDR_CORE, trig);
    seen.delete();
    repeat (20) begin
      if (sl_xfer_valid === 1'b1) seen.push_back({sl_xfer_param, sl_xfer_idx, sl_xfer_addr});
      @(negedge clk_sys);
    end
  endtask
  task automatic mod(input logic [12:0] a, input logic [12:0] e);
    dm_addr_in = a;
    @(negedge clk_sys);
    chk("dm_addr_out", {3'h0, e}, {3'h0, dm_addr_out});
  endtask

  initial begin
    n_errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    {lrclk_in, lrclk_out, slew_settled, sl_pair_wr} = 8'h00;
    sl_pair_addr = {11'h000, 11'h123, 11'h000, 11'h7ff, 11'h000};
    dm_addr_in = 13'h0000;
    rows = '{'{16'h0200, 16'h0200, 4'h4}, '{16'h0300, 16'h0300, 4'h6},
             '{16'h0240, 16'h0240, 4'h5}, '{16'h0000, 16'h0000, 4'h0},
             '{16'he800, 16'h0000, 4'h0}, '{16'h1200, 16'h1200, 4'hc},
             '{16'h040e, 16'h040e, 4'h0}};
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    chk("outputs", 16'h0000, {8'h00, slew_mute, core_clear_n, mult_zero, in_mute,
        out_latch, dm_fill_we, sl_xfer_valid, frame_start});
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("core_control", 16'h0000, v);
    foreach (rows[i]) begin
      u_dcc_host_model.wr(DCC_ADDR_CORE, rows[i].wd);
      chk("ctrl outs", {12'h0, rows[i].outs}, {12'h0, slew_mute, core_clear_n, mult_zero,
          in_mute});
      u_dcc_host_model.rd(DCC_ADDR_CORE, v);
      chk("core_control", rows[i].rb, v);
    end
    u_dcc_host_model.wr(12'ha54, 16'hffff);
    u_dcc_host_model.rd(12'ha54, v);
    chk("unmapped", 16'h0000, v);
    u_dcc_host_model.wr(DCC_ADDR_CORE, 16'h1200);
    slew_settled = 1'b1;
    repeat (3) @(negedge clk_sys);
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("muted set", 16'h3200, v);
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("muted cleared", 16'h1200, v);
    slew_settled = 1'b0;
    u_dcc_host_model.stop(16'h0200);
    chk("clear held", 16'h0000, {15'h0, core_clear_n});
    sl_run(5'b01001, 16'h0210);
    chk("sl count", 16'h0002, 16'(seen.size()));
    chk("sl pair", 16'h4000, {1'b0, seen[0]});
    chk("sl pair", 16'h5923, {1'b0, seen[1]});
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("core_control", 16'h0200, v);
    sl_run(5'b00010, 16'h0220);
    chk("sl count", 16'h0001, 16'(seen.size()));
    chk("sl pair", 16'h0fff, {1'b0, seen[0]});
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("core_control", 16'h0200, v);
    u_dcc_host_model.fill(16'h0200);
    n = 0;
    t = 0;
    while (t < 7000 && !(n > 0 && dm_fill_we !== 1'b1)) begin
      if (dm_fill_we === 1'b1) begin
        if (n == 0) f_first = dm_fill_addr;
        f_last = dm_fill_addr;
        n++;
      end
      @(negedge clk_sys);
      t++;
    end
    chk("fill count", 16'h1800, 16'(n));
    chk("fill span", 16'h17ff, {3'h0, f_last | f_first});
    if (t == 7000) wrap_up();
    u_dcc_host_model.rd(DCC_ADDR_CORE, v);
    chk("core_control", 16'h0200, v);
    for (int k = 0; k < 4; k++) begin
      v = 16'h0200 | 16'(k << 2) | 16'(u_dcc_host_model.len_for(192));
      u_dcc_host_model.wr(DCC_ADDR_CORE, v);
      n = 0;
      repeat (16) begin
        lrclk_in = ~lrclk_in;
        repeat (10) begin
          @(negedge clk_sys);
          if (frame_start === 1'b1) n++;
        end
      end
      chk("frames", 16'(8 >> k), 16'(n));
    end
    for (int k = 0; k < 4; k++) begin
      u_dcc_host_model.wr(DCC_ADDR_CORE, 16'h0200 | 16'(k));
      frame();
      n = 0;
      while (out_latch !== 1'b1 && n < 2000) begin
        @(negedge clk_sys);
        n++;
      end
      chk("steps", 16'(1536 >> k), 16'(n));
      chk("last pc", 16'((1536 >> k) - 1), {5'h00, prog_pc});
      if (n == 2000) wrap_up();
    end
    u_dcc_host_model.wr(DCC_ADDR_CORE, 16'h0600);
    n = 0;
    lrclk_out = 1'b1;
    repeat (10) begin
      @(negedge clk_sys);
      if (out_latch === 1'b1) n++;
    end
    lrclk_out = 1'b0;
    chk("out latch", 16'h0001, 16'(n));
    reset_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    chk("outputs", 16'h0000, {13'h0, core_clear_n, slew_mute, mult_zero});
    u_dcc_host_model.wr(DCC_ADDR_RAMCFG, 16'h00ff);
    u_dcc_host_model.rd(DCC_ADDR_RAMCFG, v);
    chk("ram_partition", 16'h000f, v);
    mod(13'h17ff, 13'h17ff);
    u_dcc_host_model.wr(DCC_ADDR_RAMCFG, 16'h0001);
    mod(13'h01ff, 13'h01ff);
    mod(13'h0258, 13'h0258);
    frame();
    @(negedge clk_sys);
    mod(13'h01ff, 13'h0000);
    mod(13'h0000, 13'h0001);
    wrap_up();
  end
endmodule
